// file: memory_space_decoder_tb.sv
// Purpose: Self-checking bench for the memory space decoder.
// Assumes: Inputs change on the falling edge; strobes answer one cycle after a request.
// Notes: Internal RAM is set to 2kB so the extended space start moves off its default.
`timescale 1ns/1ps
module memory_space_decoder_tb;
  import msd_pkg::*;
  localparam int IDS = 2048;
  logic        clk_sys_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        acc_rd_in = 1'b0, acc_wr_in = 1'b0, acc_code_in = 1'b0;
  logic        reg_acc_in = 1'b0, bit_acc_in = 1'b0;
  logic        fetch_next_in = 1'b0, irq_take_in = 1'b0;
  logic [1:0]  acc_mode_in = 2'h0, status_word_bank_select_in = 2'h0;
  logic [2:0]  reg_num_in = 3'h0;
  logic [3:0]  irq_num_in = 4'h0, hit_out;
  logic [23:0] acc_addr_in = 24'h000000, fetch_addr_in = 24'h000000, addr_out;
  logic [14:0] internal_data_space_raddr_out, internal_data_space_waddr_out;
  logic [22:0] extended_data_space_addr_out, prog_addr_out;
  logic [7:0]  sfr_raddr_out, sfr_waddr_out;
  logic        internal_data_space_oe_out, internal_data_space_we_out, extended_data_space_rd_out, extended_data_space_wr_out, sfr_oe_out, sfr_we_out;
  logic        prog_rd_out, prog_wr_out, prog_legacy_out, bit_area_out, unmapped_out;
  int          mismatches = 0, check_count = 0, cyc = 0;

  msd_decoder #(.INTERNAL_DATA_SPACE_SIZE(IDS)) dut (.*);
  msd_mem_model mdl (.*);

  always #2.5 clk_sys_in = ~clk_sys_in;

  task chk(input logic [23:0] g, input logic [23:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Control bits are rd, wr, code, bit; flags are legacy, bit area, unmapped.
  task acc(input logic [3:0] c, input logic [1:0] m, input logic [23:0] a,
           input logic [3:0] eh, input logic [23:0] ea, input logic [2:0] ef);
    logic [2:0] f;
    {acc_rd_in, acc_wr_in, acc_code_in, bit_acc_in} = c;
    acc_mode_in = m;
    acc_addr_in = a;
    @(negedge clk_sys_in);
    f = {prog_legacy_out, bit_area_out, unmapped_out};
    {acc_rd_in, acc_wr_in, acc_code_in, bit_acc_in} = 4'h0;
    @(negedge clk_sys_in);
    chk({21'h0, f}, {21'h0, ef});
    chk({20'h0, hit_out}, {20'h0, eh});
    chk(addr_out, ea);
  endtask

  task fet(input logic irq, input logic [23:0] a, input logic [3:0] n, input logic [23:0] ea);
    irq_take_in = irq;
    fetch_next_in = ~irq;
    fetch_addr_in = a;
    irq_num_in = n;
    @(negedge clk_sys_in);
    {irq_take_in, fetch_next_in} = 2'h0;
    repeat (2) @(negedge clk_sys_in);
    chk({20'h0, hit_out}, 24'h000008);
    chk(addr_out, ea);
  endtask

  task t_reset;
    repeat (8) @(negedge clk_sys_in);
    chk({20'h0, hit_out}, 24'h000000);
    resetn_in = 1'b1;
    @(negedge clk_sys_in);
    chk({23'h0, prog_legacy_out}, 24'h000001);
    @(negedge clk_sys_in);
    chk({20'h0, hit_out}, 24'h000008);
    chk(addr_out, 24'h7F0000);
  endtask

  task t_sfr;
    acc(4'h8, 2'h0, 24'h000090, 4'h2, 24'h000090, 3'h0);
    acc(4'h4, 2'h0, 24'h0000FF, 4'h2, 24'h0000FF, 3'h0);
    acc(4'h8, 2'h0, 24'h00007F, 4'h1, 24'h00007F, 3'h0);
    acc(4'h4, 2'h0, 24'h000010, 4'h1, 24'h000010, 3'h0);
  endtask

  task t_wide;
    for (int m = 1; m < 4; m++) begin
      acc(4'h8, m[1:0], 24'h000080, 4'h1, 24'h000080, 3'h0);
      acc(4'h4, m[1:0], 24'h0000FF, 4'h1, 24'h0000FF, 3'h0);
    end
  endtask

  task t_extended_data_space;
    acc(4'h8, 2'h3, 24'h0007FF, 4'h1, 24'h0007FF, 3'h0);
    acc(4'h8, 2'h3, 24'h000800, 4'h4, 24'h000000, 3'h0);
    acc(4'h4, 2'h3, 24'h7FFFFF, 4'h4, 24'h7FF7FF, 3'h0);
    acc(4'h8, 2'h2, 24'h800000, 4'h0, 24'h000000, 3'h1);
  endtask

  task t_prog;
    acc(4'hA, 2'h2, 24'h800000, 4'h8, 24'h000000, 3'h0);
    acc(4'hA, 2'h2, 24'hFEFFFF, 4'h8, 24'h7EFFFF, 3'h0);
    acc(4'h6, 2'h2, 24'hFF1234, 4'h8, 24'h7F1234, 3'h4);
    acc(4'hA, 2'h2, 24'h7FFFFF, 4'h0, 24'h000000, 3'h1);
  endtask

  task t_regs;
    status_word_bank_select_in = 2'h3;
    reg_num_in = 3'h7;
    reg_acc_in = 1'b1;
    acc(4'h8, 2'h0, 24'h000090, 4'h1, 24'h00001F, 3'h0);
    status_word_bank_select_in = 2'h1;
    reg_num_in = 3'h2;
    acc(4'h4, 2'h0, 24'h000090, 4'h1, 24'h00000A, 3'h0);
    reg_acc_in = 1'b0;
  endtask

  task t_bits;
    acc(4'h9, 2'h3, 24'h000020, 4'h1, 24'h000020, 3'h2);
    acc(4'h9, 2'h3, 24'h00001F, 4'h1, 24'h00001F, 3'h0);
    acc(4'h9, 2'h0, 24'h0000FF, 4'h2, 24'h0000FF, 3'h2);
  endtask

  task t_fetch;
    fet(1'b0, 24'h800100, 4'h0, 24'h000100);
    fet(1'b1, 24'h000000, 4'h0, 24'(VECTOR_BASE - PROG_BASE));
    fet(1'b1, 24'h000000, 4'hF, 24'(VECTOR_BASE - PROG_BASE + 15 * VEC_SPACING));
  endtask

  task wrap_up;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // The whole sequence needs about 65 cycles; the ceiling leaves ample slack.
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 1000) begin
      mismatches++;
      wrap_up;
    end
  end

  initial begin
    t_reset;
    t_sfr;
    t_wide;
    t_extended_data_space;
    t_prog;
    t_regs;
    t_bits;
    t_fetch;
    wrap_up;
  end
endmodule

// file: msd_decoder.sv
// Purpose: Route each core access to internal RAM, extended RAM, program memory or special registers.
// Assumes: Core presents one access per cycle; answers are registered one cycle later.
// Notes: Data buses pass straight to the memories outside; only addresses, strobes and status flags are decoded here.
`timescale 1ns/1ps
module msd_decoder
  import msd_pkg::*;
#(
  parameter int INTERNAL_DATA_SPACE_SIZE = INTERNAL_DATA_SPACE_DEF
) (
  // Clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              resetn_in,
  // Core access request
  input  wire logic              acc_rd_in,
  input  wire logic              acc_wr_in,
  input  wire logic              acc_code_in,
  input  wire logic [1:0]        acc_mode_in,
  input  wire logic [23:0]       acc_addr_in,
  input  wire logic [1:0]        status_word_bank_select_in,
  input  wire logic [2:0]        reg_num_in,
  input  wire logic              reg_acc_in,
  input  wire logic              bit_acc_in,
  // Core fetch and interrupt
  input  wire logic              fetch_next_in,
  input  wire logic [23:0]       fetch_addr_in,
  input  wire logic              irq_take_in,
  input  wire logic [3:0]        irq_num_in,
  // Internal data space
  output logic [14:0]            internal_data_space_raddr_out,
  output logic [14:0]            internal_data_space_waddr_out,
  output logic                   internal_data_space_oe_out,
  output logic                   internal_data_space_we_out,
  // Extended data space
  output logic [22:0]            extended_data_space_addr_out,
  output logic                   extended_data_space_rd_out,
  output logic                   extended_data_space_wr_out,
  // Program space
  output logic [22:0]            prog_addr_out,
  output logic                   prog_rd_out,
  output logic                   prog_wr_out,
  output logic                   prog_legacy_out,
  // Special register space
  output logic [7:0]             sfr_raddr_out,
  output logic [7:0]             sfr_waddr_out,
  output logic                   sfr_oe_out,
  output logic                   sfr_we_out,
  // Status
  output logic                   bit_area_out,
  output logic                   unmapped_out
);

  initial begin
    if (INTERNAL_DATA_SPACE_SIZE < INTERNAL_DATA_SPACE_MIN || INTERNAL_DATA_SPACE_SIZE > INTERNAL_DATA_SPACE_MAX) begin
      $error("INTERNAL_DATA_SPACE_SIZE out of range");
    end
  end

  localparam logic [23:0] EXTENDED_DATA_SPACE_BASE = 24'(INTERNAL_DATA_SPACE_SIZE);
  localparam logic [23:0] EXTENDED_DATA_SPACE_TOP  = 24'(INTERNAL_DATA_SPACE_SIZE + EXTENDED_DATA_SPACE_MAX);

  msd_mode_t   mode;
  msd_tgt_t    tgt;
  logic [23:0] eff_addr;
  logic        acc_any;
  logic [23:0] pc_r;
  logic        fetch_pend_r;

  assign mode    = msd_mode_t'(acc_mode_in);
  assign acc_any = acc_rd_in | acc_wr_in;

  // Working registers resolve to bank base plus register number.
  always_comb begin
    if (reg_acc_in) begin
      eff_addr = 24'({status_word_bank_select_in, reg_num_in});
    end else begin
      eff_addr = acc_addr_in;
    end
  end

  // Only eight-bit direct reaches special registers; the rest see RAM.
  always_comb begin
    tgt = MSD_TGT_NONE;
    if (acc_code_in) begin
      if (acc_addr_in >= PROG_BASE) begin
        tgt = MSD_TGT_PROG;
      end
    end else if (eff_addr < EXTENDED_DATA_SPACE_BASE) begin
      case (mode)
        MSD_MODE_DIR8: begin
          if (!reg_acc_in && eff_addr >= SFR_LO && eff_addr <= SFR_HI) begin
            tgt = MSD_TGT_SFR;
          end else begin
            tgt = MSD_TGT_INTERNAL_DATA_SPACE;
          end
        end
        default: tgt = MSD_TGT_INTERNAL_DATA_SPACE;
      endcase
    end else if (eff_addr < EXTENDED_DATA_SPACE_TOP && eff_addr < PROG_BASE) begin
      tgt = MSD_TGT_EXTENDED_DATA_SPACE;
    end
  end

  // Internal data strobes.
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      internal_data_space_raddr_out <= 15'h0000;
      internal_data_space_waddr_out <= 15'h0000;
      internal_data_space_oe_out    <= 1'b0;
      internal_data_space_we_out    <= 1'b0;
    end else begin
      internal_data_space_raddr_out <= eff_addr[14:0];
      internal_data_space_waddr_out <= eff_addr[14:0];
      internal_data_space_oe_out    <= (tgt == MSD_TGT_INTERNAL_DATA_SPACE) && acc_rd_in;
      internal_data_space_we_out    <= (tgt == MSD_TGT_INTERNAL_DATA_SPACE) && acc_wr_in;
    end
  end

  // Extended data strobes, offset so the first location follows internal RAM.
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      extended_data_space_addr_out <= 23'h000000;
      extended_data_space_rd_out   <= 1'b0;
      extended_data_space_wr_out   <= 1'b0;
    end else begin
      extended_data_space_addr_out <= 23'(eff_addr - EXTENDED_DATA_SPACE_BASE);
      extended_data_space_rd_out   <= (tgt == MSD_TGT_EXTENDED_DATA_SPACE) && acc_rd_in;
      extended_data_space_wr_out   <= (tgt == MSD_TGT_EXTENDED_DATA_SPACE) && acc_wr_in;
    end
  end

  // Separate read and write buses let a read-modify-write overlap.
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      sfr_raddr_out <= 8'h00;
      sfr_waddr_out <= 8'h00;
      sfr_oe_out    <= 1'b0;
      sfr_we_out    <= 1'b0;
    end else begin
      sfr_raddr_out <= eff_addr[7:0];
      sfr_waddr_out <= eff_addr[7:0];
      sfr_oe_out    <= (tgt == MSD_TGT_SFR) && acc_rd_in;
      sfr_we_out    <= (tgt == MSD_TGT_SFR) && acc_wr_in;
    end
  end

  // Program counter: reset fetch and vectors win over data reads of code.
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      pc_r         <= RESET_FETCH;
      fetch_pend_r <= 1'b1;
    end else begin
      fetch_pend_r <= 1'b0;
      if (irq_take_in) begin
        pc_r         <= VECTOR_BASE + 24'({irq_num_in, 3'h0});
        fetch_pend_r <= 1'b1;
      end else if (fetch_next_in) begin
        pc_r         <= fetch_addr_in;
        fetch_pend_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      prog_addr_out   <= 23'h000000;
      prog_rd_out     <= 1'b0;
      prog_wr_out     <= 1'b0;
      prog_legacy_out <= 1'b0;
    end else if (fetch_pend_r) begin
      prog_addr_out   <= pc_r[22:0];
      prog_rd_out     <= 1'b1;
      prog_wr_out     <= 1'b0;
      prog_legacy_out <= pc_r >= LEGACY_BASE;
    end else begin
      prog_addr_out   <= acc_addr_in[22:0];
      prog_rd_out     <= (tgt == MSD_TGT_PROG) && acc_rd_in;
      prog_wr_out     <= (tgt == MSD_TGT_PROG) && acc_wr_in;
      prog_legacy_out <= acc_addr_in >= LEGACY_BASE;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      bit_area_out <= 1'b0;
      unmapped_out <= 1'b0;
    end else begin
      bit_area_out <= bit_acc_in && !acc_code_in && eff_addr >= BIT_AREA_LO
                      && eff_addr <= BIT_AREA_HI;
      unmapped_out <= acc_any && (tgt == MSD_TGT_NONE);
    end
  end

  sfr_direct_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    acc_rd_in && !acc_code_in && !reg_acc_in && mode == MSD_MODE_DIR8 && acc_addr_in >= SFR_LO
    && acc_addr_in <= SFR_HI |=> sfr_oe_out && !internal_data_space_oe_out)
    else $error("Direct high byte did not reach special registers");

  wide_ram_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    acc_rd_in && !acc_code_in && mode != MSD_MODE_DIR8 && acc_addr_in >= SFR_LO
    && acc_addr_in <= SFR_HI |=> internal_data_space_oe_out && !sfr_oe_out)
    else $error("Wide mode high byte did not reach internal RAM");

  low_direct_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    acc_wr_in && !acc_code_in && !reg_acc_in && acc_addr_in < SFR_LO |=> internal_data_space_we_out && !sfr_we_out)
    else $error("Low direct write missed internal RAM");

  extended_data_space_start_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    acc_rd_in && !acc_code_in && !reg_acc_in && acc_addr_in == EXTENDED_DATA_SPACE_BASE
    |=> extended_data_space_rd_out && extended_data_space_addr_out == 23'h000000 && !internal_data_space_oe_out)
    else $error("First extended address misplaced");

  bank_addr_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    acc_rd_in && !acc_code_in && reg_acc_in
    |=> internal_data_space_oe_out && internal_data_space_raddr_out == 15'({$past(status_word_bank_select_in), $past(reg_num_in)}))
    else $error("Bank register address wrong");

  reset_fetch_a: assert property (@(posedge clk_sys_in)
    !resetn_in ##1 resetn_in |=> prog_rd_out && prog_addr_out == RESET_FETCH[22:0] && prog_legacy_out)
    else $error("First fetch not at reset address");

  vector_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    irq_take_in ##1 1'b1 |=> prog_rd_out
    && prog_addr_out == 23'(VECTOR_BASE + 24'({$past(irq_num_in, 2), 3'h0})))
    else $error("Vector fetch address wrong");

  prog_low_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    acc_code_in && acc_rd_in && acc_addr_in < PROG_BASE && !fetch_pend_r |=> !prog_rd_out && unmapped_out)
    else $error("Code access below program base accepted");

  bit_area_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    bit_acc_in && !acc_code_in && !reg_acc_in && acc_addr_in < BIT_AREA_LO |=> !bit_area_out)
    else $error("Bit area flagged below its base");

endmodule

// file: msd_mem_model.sv
// Purpose: Memory-side observer for the decoder strobes.
// Assumes: Strobes are registered one-cycle pulses from the decoder.
// Notes: Records, each cycle, which spaces were strobed and at which address.
`timescale 1ns/1ps
module msd_mem_model (
  // Clock
  input  wire logic        clk_sys_in,
  // Decoder side, named as the decoder ports so the bench can wire by name
  input  wire logic [14:0] internal_data_space_raddr_out,
  input  wire logic [14:0] internal_data_space_waddr_out,
  input  wire logic        internal_data_space_oe_out,
  input  wire logic        internal_data_space_we_out,
  input  wire logic [22:0] extended_data_space_addr_out,
  input  wire logic        extended_data_space_rd_out,
  input  wire logic        extended_data_space_wr_out,
  input  wire logic [22:0] prog_addr_out,
  input  wire logic        prog_rd_out,
  input  wire logic        prog_wr_out,
  input  wire logic [7:0]  sfr_raddr_out,
  input  wire logic [7:0]  sfr_waddr_out,
  input  wire logic        sfr_oe_out,
  input  wire logic        sfr_we_out,
  // Observed access
  output logic [3:0]       hit_out,
  output logic [23:0]      addr_out
);
  // A hit mask, not a single code, so two spaces strobed at once show up.
  always_ff @(posedge clk_sys_in) begin
    hit_out <= {prog_rd_out | prog_wr_out, extended_data_space_rd_out | extended_data_space_wr_out,
                sfr_oe_out | sfr_we_out, internal_data_space_oe_out | internal_data_space_we_out};
    if (prog_rd_out | prog_wr_out) addr_out <= {1'b0, prog_addr_out};
    else if (extended_data_space_rd_out | extended_data_space_wr_out) addr_out <= {1'b0, extended_data_space_addr_out};
    else if (sfr_oe_out) addr_out <= {16'h0000, sfr_raddr_out};
    else if (sfr_we_out) addr_out <= {16'h0000, sfr_waddr_out};
    else if (internal_data_space_oe_out) addr_out <= {9'h000, internal_data_space_raddr_out};
    else if (internal_data_space_we_out) addr_out <= {9'h000, internal_data_space_waddr_out};
    else addr_out <= 24'h000000;
  end
endmodule

// file: msd_pkg.sv
// Purpose: Constants and types for the memory space decoder.
// Assumes: One system clock, synchronous active-low reset.
// Notes: Addresses are 24-bit byte addresses of the unified space.
// Notes on behaviour
// - Low RAM holds four banks of eight registers.
// - Bytes 0x20 to 0xFF are bit addressable.
// - Wide modes at 0x80-0xFF reach internal RAM.
// - Eight-bit direct at 0x80-0xFF reaches special registers.
// - Extended data starts right after internal RAM.
// - Program memory spans 0x800000 to top, 8MB.
// - Region 0xFF0000-0xFFFFFF holds legacy code.
// - Fetch starts at 0xFF0000 after reset.
// - Each interrupt vector offset from base 0xFF0000.
// - Internal up to 32kB, extended up to 8MB.
// - Internal size chosen at build, 1kB-32kB.
// - Special registers use separate read/write strobed buses.
package msd_pkg;
  localparam int          ADDR_W        = 24;
  localparam int          BANK_COUNT    = 4;
  localparam int          BANK_REGS     = 8;
  localparam logic [23:0] BIT_AREA_LO   = 24'h000020;
  localparam logic [23:0] BIT_AREA_HI   = 24'h0000FF;
  localparam logic [23:0] SFR_LO        = 24'h000080;
  localparam logic [23:0] SFR_HI        = 24'h0000FF;
  localparam logic [23:0] PROG_BASE     = 24'h800000;
  localparam logic [23:0] LEGACY_BASE   = 24'hFF0000;
  localparam logic [23:0] RESET_FETCH   = 24'hFF0000;
  localparam logic [23:0] VECTOR_BASE   = 24'hFF0000;
  localparam int          INTERNAL_DATA_SPACE_MIN     = 1024;
  localparam int          INTERNAL_DATA_SPACE_MAX     = 32768;
  localparam int          INTERNAL_DATA_SPACE_DEF     = 1024;
  localparam int          EXTENDED_DATA_SPACE_MAX     = 8388608;
  localparam int          VEC_SPACING   = 8;
  localparam int          VEC_COUNT     = 16;

  typedef enum logic [1:0] {
    MSD_MODE_DIR8,
    MSD_MODE_DIR16,
    MSD_MODE_DIR24,
    MSD_MODE_IND
  } msd_mode_t;

  typedef enum {
    MSD_TGT_NONE,
    MSD_TGT_INTERNAL_DATA_SPACE,
    MSD_TGT_SFR,
    MSD_TGT_EXTENDED_DATA_SPACE,
    MSD_TGT_PROG
  } msd_tgt_t;
endpackage
